// >>> hdl/loop_fsm_defs.vh
// What this block does
// [RULE1] A one-cycle start pulse from outside begins the machine.
// [RULE2] Finish output pulses exactly one cycle when the machine completes.
// [RULE3] Optional enable input; when unused it is tied high.
// [RULE4] Single-bit condition inputs feed the transition expressions.
// [RULE5] Each state tests its conditions in order; first true picks next state, outputs.
// [RULE6] Every transition drives one 0/1 value to each declared output.
// [RULE7] No default and nothing true: stay in state, all outputs zero.
// [RULE8] Transition machine pulses finish on return to initial state after start.
// [RULE9] Counter starts at init, adds step, continues while compare against limit holds.
// [RULE10] Loop exposes body start, done, empty, first, last, valid, counter.
// [RULE11] Inner loop limit may be the outer loop counter: triangular spaces.
// [RULE12] Units sequence by passing start token; sequences may sit inside loops.
// [RULE13] Early-end strategy runs innermost loop one fewer iteration.
// [RULE14] Early-end raises last and done flags one cycle earlier.
// [RULE15] Enable low holds state, counters, outputs and ignores start; finish is cleared instead of held, and the loop units' valid flags go low.
`ifndef LOOP_FSM_DEFS_VH
`define LOOP_FSM_DEFS_VH
// ****************************************
// Widths and comparison codes
// ****************************************
`define CNT_W 8
`define CMP_LT 2'h0
`define CMP_LE 2'h1
`define CMP_GT 2'h2
`define CMP_GE 2'h3
// ****************************************
// Transition machine states
// ****************************************
`define ST_START 2'h0
`define ST_NEXT 2'h1
`define ST_W 2
`define OUT_W 2
// ****************************************
// Default loop settings
// ****************************************
`define ROW_INIT 8'h00
`define ROW_LIMIT 8'h08
`define COL_INIT 8'h00
`define STEP_DEF 8'h01
`endif

// >>> hdl/loop_counter_unit.v
`timescale 1ns/1ps
`include "loop_fsm_defs.vh"
module loop_counter_unit
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire en,
  input wire go,
  input wire [1:0] cmp_op,
  input wire [`CNT_W-1:0] init,
  input wire [`CNT_W-1:0] step,
  input wire [`CNT_W-1:0] limit,
  input wire end_early,
  // Status
  output wire body_start_flag,
  output reg loop_done_flag,
  output wire empty_loop_flag,
  output wire first_iteration_flag,
  output wire last_iteration_flag,
  output wire valid,
  output wire [`CNT_W-1:0] counter
);
  // ****************************************
  // Compare helper
  // ****************************************
  // Signed compare so downward loops with negative step work
  function cmp_ok;
    input [1:0] op;
    input [`CNT_W-1:0] a;
    input [`CNT_W-1:0] b;
    begin
      case (op)
        `CMP_LT: cmp_ok = $signed(a) < $signed(b);
        `CMP_LE: cmp_ok = $signed(a) <= $signed(b);
        `CMP_GT: cmp_ok = $signed(a) > $signed(b);
        default: cmp_ok = $signed(a) >= $signed(b);
      endcase
    end
  endfunction

  reg run_q;
  reg first_q;
  reg [`CNT_W-1:0] cnt_q;
  reg [`CNT_W-1:0] lim_q;
  wire [`CNT_W-1:0] eff_lim;
  wire [`CNT_W-1:0] nxt;
  wire more;
  wire ok0;

  // Limit shortened by one step pulls last and done one cycle earlier
  assign eff_lim = end_early ? limit - step : limit; // [RULE13] [RULE14]
  assign nxt = cnt_q + step;
  assign more = cmp_ok(cmp_op, nxt, lim_q); // [RULE9]
  assign ok0 = cmp_ok(cmp_op, init, eff_lim);

  // ****************************************
  // Counter
  // ****************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_q <= 1'b0;
      first_q <= 1'b0;
      cnt_q <= 8'h00;
      lim_q <= 8'h00;
      loop_done_flag <= 1'b0;
    end
    else if (en) // [RULE15]
    begin
      loop_done_flag <= 1'b0;
      if (go && !run_q)
      begin
        cnt_q <= init; // [RULE9]
        lim_q <= eff_lim; // [RULE11]
        first_q <= 1'b1;
        run_q <= ok0;
        loop_done_flag <= !ok0;
      end
      else if (run_q)
      begin
        first_q <= 1'b0;
        if (more)
          cnt_q <= nxt;
        else
        begin
          run_q <= 1'b0;
          loop_done_flag <= 1'b1;
        end
      end
    end
  end

  assign valid = run_q && en; // [RULE10]
  assign body_start_flag = valid;
  assign first_iteration_flag = valid && first_q;
  assign last_iteration_flag = valid && !more;
  assign empty_loop_flag = en && go && !run_q && !ok0;
  assign counter = cnt_q;
endmodule

// >>> hdl/transition_machine.v
`timescale 1ns/1ps
`include "loop_fsm_defs.vh"
module transition_machine
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire en,
  input wire go,
  input wire [1:0] cond,
  // Outputs
  output reg [`OUT_W-1:0] outs,
  output reg finish,
  output wire [`ST_W-1:0] state
);
  reg [`ST_W-1:0] st_q;
  reg [`ST_W-1:0] st_d;
  reg [`OUT_W-1:0] out_d;
  reg act_q;

  // ****************************************
  // Transition table
  // ****************************************
  // Start waits for the token and cond[0], Next returns while cond[1] is high
  always @*
  begin
    st_d = st_q; // [RULE7]
    out_d = 2'h0; // [RULE7]
    case (st_q)
      `ST_START:
      begin
        if ((go || act_q) && cond[0]) // [RULE4] [RULE5]
        begin
          st_d = `ST_NEXT;
          out_d = 2'h1; // [RULE6]
        end
      end
      `ST_NEXT:
      begin
        if (cond[1]) // [RULE5]
        begin
          st_d = `ST_START;
          out_d = 2'h2; // [RULE6]
        end
        else
          out_d = 2'h3; // [RULE5]
      end
      default:
        st_d = `ST_START;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= `ST_START;
      outs <= 2'h0;
      finish <= 1'b0;
      act_q <= 1'b0;
    end
    else if (en) // [RULE15]
    begin
      st_q <= st_d;
      outs <= out_d;
      if (go) // [RULE1]
        act_q <= 1'b1;
      finish <= 1'b0;
      if (st_q == `ST_NEXT && st_d == `ST_START)
      begin
        finish <= 1'b1; // [RULE8]
        act_q <= 1'b0;
      end
    end
    // Token held while disabled so the next stage still sees it [RULE15]
  end

  assign state = st_q;
endmodule

// >>> hdl/loop_and_transition_fsm.v
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "loop_fsm_defs.vh"
module loop_and_transition_fsm
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Machine controls
  input wire start,
  input wire enable,
  input wire [1:0] cond,
  // Sequence results
  output wire [`OUT_W-1:0] tm_outs,
  output reg [`CNT_W-1:0] row_count,
  output reg [`CNT_W-1:0] col_count,
  output reg col_valid,
  output reg col_first,
  output reg col_last,
  output reg row_done,
  output reg row_empty,
  output reg finish
);
  // ****************************************
  // Register map
  // ****************************************
  localparam [7:0] A_CTRL = 8'h00;
  localparam [7:0] A_ROW = 8'h04;
  localparam [7:0] A_COL = 8'h08;
  localparam [7:0] A_STAT = 8'h0c;
  localparam [7:0] A_CNT = 8'h10;

  // ctrl: [0] use enable pin, [1] end early, [2] triangular, [3] use transition stage
  reg [3:0] ctrl_q;
  // row/col: [7:0] init, [15:8] step, [23:16] limit, [25:24] compare
  reg [25:0] row_cfg_q;
  reg [25:0] col_cfg_q;
  reg [7:0] runs_q;

  // ****************************************
  // Bus write side
  // ****************************************
  reg [7:0] aw_q;
  reg aw_ok_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg wd_ok_q;
  wire do_wr;
  wire [31:0] ctrl_m;
  wire [31:0] row_m;
  wire [31:0] col_m;

  assign s_axi_awready = !aw_ok_q && !s_axi_bvalid;
  assign s_axi_wready = !wd_ok_q && !s_axi_bvalid;
  assign do_wr = aw_ok_q && wd_ok_q && !s_axi_bvalid;

  // Apply byte lanes to a stored word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        merge[k*8 +: 8] = st[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
    end
  endfunction

  assign ctrl_m = merge({28'h0, ctrl_q}, wd_q, ws_q);
  assign row_m = merge({6'h0, row_cfg_q}, wd_q, ws_q);
  assign col_m = merge({6'h0, col_cfg_q}, wd_q, ws_q);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 8'h00;
      aw_ok_q <= 1'b0;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      wd_ok_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_q <= 4'h0;
      row_cfg_q <= {`CMP_LT, `ROW_LIMIT, `STEP_DEF, `ROW_INIT};
      col_cfg_q <= {`CMP_LT, `ROW_LIMIT, `STEP_DEF, `COL_INIT};
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= s_axi_awaddr;
        aw_ok_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        wd_ok_q <= 1'b1;
      end
      if (do_wr)
      begin
        aw_ok_q <= 1'b0;
        wd_ok_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_q)
          A_CTRL: ctrl_q <= ctrl_m[3:0];
          A_ROW: row_cfg_q <= row_m[25:0];
          A_COL: col_cfg_q <= col_m[25:0];
          A_STAT, A_CNT: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Machine enable and sequence
  // ****************************************
  wire en_eff;
  wire go_q;
  wire row_go;
  wire tm_fin;
  wire [`ST_W-1:0] tm_state;
  wire r_ld, r_el, r_ll, r_v;
  wire c_ld, c_fl, c_ll, c_v;
  wire row_en;
  wire kick_d;
  wire [`CNT_W-1:0] r_cnt;
  wire [`CNT_W-1:0] c_cnt;
  wire [`CNT_W-1:0] c_limit;
  wire c_go;
  reg col_kick_q;
  reg busy_q;

  assign en_eff = ctrl_q[0] ? enable : 1'b1; // [RULE3]
  // Start accepted only while idle; a second pulse mid-run is dropped
  assign go_q = en_eff && start && !busy_q; // [RULE1]

  // Optional transition stage runs first and hands its token to the loops
  transition_machine u_tm
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(en_eff),
    .go(go_q && ctrl_q[3]),
    .cond(cond),
    .outs(tm_outs),
    .finish(tm_fin),
    .state(tm_state)
  );

  assign row_go = ctrl_q[3] ? tm_fin : go_q; // [RULE12]
  // Outer loop moves only to start, to step after an inner pass, and to drop its done flag
  assign row_en = en_eff && (row_go || c_ld || r_ld); // [RULE11] [RULE15]
  // Inner pass launched after the outer start and after each non-final inner pass
  assign kick_d = (row_go && !r_el) || (c_ld && !r_ll); // [RULE12]

  loop_counter_unit u_row
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(row_en),
    .go(row_go),
    .cmp_op(row_cfg_q[25:24]),
    .init(row_cfg_q[7:0]),
    .step(row_cfg_q[15:8]),
    .limit(row_cfg_q[23:16]),
    .end_early(1'b0),
    .body_start_flag(),
    .loop_done_flag(r_ld),
    .empty_loop_flag(r_el),
    .first_iteration_flag(),
    .last_iteration_flag(r_ll),
    .valid(r_v),
    .counter(r_cnt)
  );

  // Outer loop steps once per finished inner pass; it stalls while the inner runs
  assign c_limit = ctrl_q[2] ? r_cnt : col_cfg_q[23:16]; // [RULE11]
  assign c_go = col_kick_q; // [RULE12]

  loop_counter_unit u_col
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(en_eff),
    .go(c_go),
    .cmp_op(col_cfg_q[25:24]),
    .init(col_cfg_q[7:0]),
    .step(col_cfg_q[15:8]),
    .limit(c_limit),
    .end_early(ctrl_q[1]),
    .body_start_flag(),
    .loop_done_flag(c_ld),
    .empty_loop_flag(),
    .first_iteration_flag(c_fl),
    .last_iteration_flag(c_ll),
    .valid(c_v),
    .counter(c_cnt)
  );

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      col_kick_q <= 1'b0;
      busy_q <= 1'b0;
      runs_q <= 8'h00;
      finish <= 1'b0;
      row_count <= 8'h00;
      col_count <= 8'h00;
      col_valid <= 1'b0;
      col_first <= 1'b0;
      col_last <= 1'b0;
      row_done <= 1'b0;
      row_empty <= 1'b0;
    end
    else if (en_eff) // [RULE15]
    begin
      col_kick_q <= kick_d;
      if (go_q)
        busy_q <= 1'b1;
      finish <= 1'b0;
      // Done also follows an empty outer loop, so one pulse covers both endings
      if (r_ld)
      begin
        busy_q <= 1'b0;
        finish <= 1'b1; // [RULE2]
        runs_q <= runs_q + 8'h01;
      end
      row_count <= r_cnt; // [RULE10]
      col_count <= c_cnt;
      col_valid <= c_v;
      col_first <= c_fl;
      col_last <= c_ll; // [RULE14]
      row_done <= r_ld;
      row_empty <= r_el;
    end
    else
      finish <= 1'b0;
  end

  // ****************************************
  // Bus read side
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        A_CTRL: s_axi_rdata <= {28'h0, ctrl_q};
        A_ROW: s_axi_rdata <= {6'h0, row_cfg_q};
        A_COL: s_axi_rdata <= {6'h0, col_cfg_q};
        A_STAT: s_axi_rdata <= {24'h0, busy_q, r_v, c_v, en_eff, tm_state, tm_outs};
        A_CNT: s_axi_rdata <= {8'h0, runs_q, c_cnt, r_cnt};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// >>> test/fsm_partner.sv
`timescale 1ns/1ps
// ****
// Datapath model: start token, enable pin, conditions
// ****
module fsm_partner
(
  // Clock
  input wire aclk,
  // Machine controls
  output logic start = 1'b0,
  output logic enable = 1'b1,
  output logic [1:0] cond = 2'h0
);
  // Token is exactly one cycle, never held over
  task pulse;
    begin
      @(posedge aclk);
      start <= 1'b1;
      @(posedge aclk);
      start <= 1'b0;
    end
  endtask
  // Enable and condition bits change only after an edge
  task drive(input logic en, input logic [1:0] c);
    begin
      @(posedge aclk);
      enable <= en;
      cond <= c;
    end
  endtask
endmodule

// >>> test/loop_and_transition_fsm_chk.sv
`timescale 1ns/1ps
module loop_and_transition_fsm_chk
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Sequence results
  input wire finish,
  input wire col_valid,
  input wire col_first,
  input wire col_last
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  fin_pulse_a: assert property (finish |=> !finish) else $error("finish too long");
  flag_valid_a: assert property (col_first || col_last |-> col_valid)
    else $error("flag without valid");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad bresp");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("aw or w taken");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write late");
  cover property (finish);
  cover property (col_last);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind loop_and_transition_fsm loop_and_transition_fsm_chk chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .finish,
  .col_valid, .col_first, .col_last);

// >>> test/loop_and_transition_fsm_tb.sv
`timescale 1ns/1ps
`include "loop_fsm_defs.vh"
module loop_and_transition_fsm_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ci, cl, cs, c;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [1:0] rs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, cond, tm_outs;
  wire [31:0] s_axi_rdata;
  wire start, enable, finish, col_valid, col_first, col_last, row_done, row_empty;
  wire [`CNT_W-1:0] row_count, col_count;
  integer err_count = 0, cmp_count = 0, seed = 32'h9bb6;
  integer nv, nf, nl, ne, nfin, nd, lim, op;
  always #5 aclk = ~aclk;
  fsm_partner part (.aclk(aclk), .start(start), .enable(enable), .cond(cond));
  loop_and_transition_fsm dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .start(start), .enable(enable), .cond(cond),
    .tm_outs(tm_outs), .row_count(row_count), .col_count(col_count), .col_valid(col_valid),
    .col_first(col_first), .col_last(col_last), .row_done(row_done), .row_empty(row_empty),
    .finish(finish));
  // ****
  // Checking and ending
  // ****
  task stop_test;
    begin
      if (err_count == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Iterations a loop unit should make; bounded since a wrapping count never ends
  function integer iters(input logic [7:0] i, s, l, input logic [1:0] o);
    integer n;
    begin
      n = 0;
      while (n < 300 && (o == 0 ? i < l : o == 1 ? i <= l : o == 2 ? i > l : i >= l))
      begin
        n = n + 1;
        i = i + s;
      end
      iters = n;
    end
  endfunction
  // ****
  // Register bus master
  // ****
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd_reg(input logic [7:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  // ****
  // Sequence runs
  // ****
  always @(posedge aclk)
  begin
    nv = nv + col_valid;
    nf = nf + col_first;
    nl = nl + col_last;
    ne = ne + row_empty;
    nfin = nfin + finish;
    nd = nd + row_done;
  end
  // Mode 1 steps the transition stage, mode 2 pauses mid-run (counts then skipped)
  task run(input integer ev, input integer el, input integer mode);
    integer n;
    begin
      {nv, nf, nl, ne, nfin, nd} = 0;
      part.pulse;
      if (mode == 1)
      begin
        repeat (4) @(posedge aclk);
        chk({30'h0, tm_outs}, 32'h0);
        chk(nv, 0);
        part.drive(1'b1, 2'h1);
        repeat (4) @(posedge aclk);
        chk({30'h0, tm_outs}, 32'h3);
        part.drive(1'b1, 2'h2);
      end
      if (mode == 2)
      begin
        repeat (6) @(posedge aclk);
        part.drive(1'b0, 2'h0);
        repeat (2) @(posedge aclk);
        c = col_count;
        repeat (5) @(posedge aclk);
        chk({24'h0, col_count}, {24'h0, c});
        part.drive(1'b1, 2'h0);
      end
      n = 0;
      while (nfin == 0 && n < 3000)
      begin
        @(posedge aclk);
        n = n + 1;
      end
      repeat (4) @(posedge aclk);
      if (ev >= 0)
      begin
        chk(nv, ev);
        chk(nf, el);
        chk(nl, el);
      end
      chk(nfin, 1);
      chk(nd, 1);
    end
  endtask
  initial
  begin
    #500000;
    err_count = err_count + 1;
    stop_test;
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(8'h04);
    chk(rd, 32'h00080100);
    rd_reg(8'h40);
    chk({30'h0, rs}, 32'h2);
    wr_reg(8'h40, 32'h1);
    chk({30'h0, rs}, 32'h2);
    // Pin low but unused: machine must still run
    part.drive(1'b0, 2'h0);
    wr_reg(8'h04, 32'h00030100);
    wr_reg(8'h08, 32'h00040100);
    run(12, 3, 0);
    chk({24'h0, row_count}, 32'h2);
    chk({24'h0, col_count}, 32'h3);
    rd_reg(8'h10);
    chk(rd, 32'h00010302);
    wr_reg(8'h00, 32'h2);
    run(9, 3, 0);
    wr_reg(8'h00, 32'h4);
    wr_reg(8'h04, 32'h00040101);
    run(6, 3, 0);
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h04, 32'h00010100);
    for (op = 0; op < 4; op = op + 1)
    begin
      lim = 1 + $unsigned($random(seed)) % 6;
      ci = (op < 2) ? 8'h00 : lim[7:0];
      cl = (op < 2) ? lim[7:0] : {7'h0, op[0]};
      cs = (op < 2) ? 8'h01 : 8'hff;
      wr_reg(8'h08, {6'h0, op[1:0], cl, cs, ci});
      run(iters(ci, cs, cl, op[1:0]), 1, 0);
    end
    wr_reg(8'h04, 32'h00000100);
    run(0, 0, 0);
    chk(ne != 0, 1);
    wr_reg(8'h00, 32'h8);
    wr_reg(8'h04, 32'h00020100);
    wr_reg(8'h08, 32'h00020100);
    run(4, 2, 1);
    part.drive(1'b0, 2'h0);
    wr_reg(8'h00, 32'h1);
    wr_reg(8'h08, 32'h00080100);
    {nv, nf, nl, ne, nfin} = 0;
    part.pulse;
    repeat (6) @(posedge aclk);
    chk(nv + nfin, 0);
    part.drive(1'b1, 2'h0);
    run(-1, 0, 2);
    stop_test;
  end
endmodule
